// File: rtl/pfcu_host.sv
// Host controller that drives the parallel flash pins for read, program, erase and identify.
`timescale 1ns/100ps
module pfcu_host #(
  parameter int ERASE_WAIT = pfcu_pkg::ERASE_CYC
) (
  input  wire logic                        clock_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        cmd_valid_i,
  input  wire logic [2:0]                  cmd_op_i,
  input  wire logic [pfcu_pkg::ADDR_W-1:0] cmd_addr_i,
  input  wire logic [pfcu_pkg::DATA_W-1:0] cmd_data_i,
  output logic                             cmd_ready_o,
  output logic                             done_o,
  output logic                             fail_o,
  output logic [pfcu_pkg::DATA_W-1:0]      rdata_o,
  output logic [pfcu_pkg::ADDR_W-1:0]      flash_addr_o,
  output logic [pfcu_pkg::DATA_W-1:0]      flash_dq_o,
  output logic                             flash_dq_oe_o,
  input  wire logic [pfcu_pkg::DATA_W-1:0] flash_dq_i,
  output logic                             chip_sel_n_o,
  output logic                             out_gate_n_o,
  output logic                             write_strobe_n_o,
  output logic                             program_supply_raised_level_o,
  output logic                             addr_bit_nine_hv_o
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_SEQ, ST_WR_SET, ST_WR_PULSE, ST_WR_HOLD, ST_RD, ST_RD_FLOAT, ST_WAIT
  } pfcu_state_t;

  pfcu_state_t                  state_q;
  pfcu_pkg::pfcu_op_t           op_q;
  logic [3:0]                   step_q;
  logic [pfcu_pkg::ADDR_W-1:0]  addr_q;
  logic [pfcu_pkg::DATA_W-1:0]  data_q;
  logic [pfcu_pkg::DATA_W-1:0]  rd_q;
  logic [pfcu_pkg::CNT_W-1:0]   cnt_q;
  logic [pfcu_pkg::TRY_W-1:0]   try_q;
  logic [pfcu_pkg::DATA_W-1:0]  dq_s1_q;
  logic [pfcu_pkg::DATA_W-1:0]  dq_s2_q;

  pfcu_pkg::pfcu_act_t          act;
  logic [3:0]                   act_step;
  logic [pfcu_pkg::DATA_W-1:0]  act_byte;
  logic [pfcu_pkg::CNT_W-1:0]   act_cnt;
  logic [pfcu_pkg::TRY_W-1:0]   try_max;

  // The data pins come from another domain, so two flops precede every use.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
    end else begin
      dq_s1_q <= flash_dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  // Chooses the next bus action from the operation and its step.
  always_comb begin
    act      = pfcu_pkg::PFCU_ACT_DONE;
    act_step = step_q + 4'h1;
    act_byte = data_q;
    act_cnt  = '0;
    try_max  = (op_q == pfcu_pkg::PFCU_OP_ERASE) ?
               pfcu_pkg::TRY_W'(pfcu_pkg::ERASE_TRIES - 1) :
               pfcu_pkg::TRY_W'(pfcu_pkg::PROG_TRIES - 1);
    case (op_q)
      pfcu_pkg::PFCU_OP_READ: begin
        case (step_q)
          4'h0: begin act = pfcu_pkg::PFCU_ACT_WR; act_byte = pfcu_pkg::CMD_READ; end
          4'h1: act = pfcu_pkg::PFCU_ACT_RD;
          default: act = pfcu_pkg::PFCU_ACT_DONE;
        endcase
      end
      pfcu_pkg::PFCU_OP_PROGRAM: begin
        case (step_q)
          4'h0: begin act = pfcu_pkg::PFCU_ACT_WR; act_byte = pfcu_pkg::CMD_PROG; end
          4'h1: act = pfcu_pkg::PFCU_ACT_WR;
          4'h2: begin
            act     = pfcu_pkg::PFCU_ACT_WAIT;
            act_cnt = pfcu_pkg::CNT_W'(pfcu_pkg::PROG_CYC);
          end
          4'h3: begin act = pfcu_pkg::PFCU_ACT_WR; act_byte = pfcu_pkg::CMD_PVER; end
          4'h4: begin act = pfcu_pkg::PFCU_ACT_WAIT; act_cnt = pfcu_pkg::CNT_W'(pfcu_pkg::REC_CYC); end
          4'h5: act = pfcu_pkg::PFCU_ACT_RD;
          default: begin
            if (rd_q == data_q) act = pfcu_pkg::PFCU_ACT_DONE;
            else if (try_q == try_max) act = pfcu_pkg::PFCU_ACT_FAIL;
            else act = pfcu_pkg::PFCU_ACT_RETRY;
          end
        endcase
      end
      pfcu_pkg::PFCU_OP_ERASE: begin
        case (step_q)
          4'h0, 4'h1: begin
            act      = pfcu_pkg::PFCU_ACT_WR;
            act_byte = pfcu_pkg::CMD_ERASE;
          end
          4'h2: begin
            act     = pfcu_pkg::PFCU_ACT_WAIT;
            act_cnt = pfcu_pkg::CNT_W'(ERASE_WAIT);
          end
          4'h3: begin act = pfcu_pkg::PFCU_ACT_WR; act_byte = pfcu_pkg::CMD_EVER; end
          4'h4: begin act = pfcu_pkg::PFCU_ACT_WAIT; act_cnt = pfcu_pkg::CNT_W'(pfcu_pkg::REC_CYC); end
          4'h5: act = pfcu_pkg::PFCU_ACT_RD;
          default: begin
            if (rd_q == pfcu_pkg::ERASED_VAL) begin
              if (addr_q == pfcu_pkg::ADDR_LAST) act = pfcu_pkg::PFCU_ACT_DONE;
              else act = pfcu_pkg::PFCU_ACT_NEXT;
            end
            else if (try_q == try_max) act = pfcu_pkg::PFCU_ACT_FAIL;
            else act = pfcu_pkg::PFCU_ACT_RETRY;
          end
        endcase
      end
      pfcu_pkg::PFCU_OP_IDENT: begin
        case (step_q)
          4'h0: begin act = pfcu_pkg::PFCU_ACT_WR; act_byte = pfcu_pkg::CMD_IDENT; end
          4'h1: act = pfcu_pkg::PFCU_ACT_RD;
          default: act = pfcu_pkg::PFCU_ACT_DONE;
        endcase
      end
      pfcu_pkg::PFCU_OP_RESET: begin
        case (step_q)
          4'h0, 4'h1: begin
            act      = pfcu_pkg::PFCU_ACT_WR;
            act_byte = pfcu_pkg::CMD_RESET;
          end
          default: act = pfcu_pkg::PFCU_ACT_DONE;
        endcase
      end
      pfcu_pkg::PFCU_OP_IDENT_HV: begin
        case (step_q)
          4'h0: act = pfcu_pkg::PFCU_ACT_RD;
          default: act = pfcu_pkg::PFCU_ACT_DONE;
        endcase
      end
      default: act = pfcu_pkg::PFCU_ACT_FAIL;
    endcase
  end

  // Sequencer and pin drive; every pin is a flop so the bus never glitches.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q                       <= ST_IDLE;
      op_q                          <= pfcu_pkg::PFCU_OP_READ;
      step_q                        <= 4'h0;
      addr_q                        <= '0;
      data_q                        <= 8'h00;
      rd_q                          <= 8'h00;
      cnt_q                         <= '0;
      try_q                         <= '0;
      cmd_ready_o                   <= 1'b0;
      done_o                        <= 1'b0;
      fail_o                        <= 1'b0;
      rdata_o                       <= 8'h00;
      flash_addr_o                  <= '0;
      flash_dq_o                    <= 8'h00;
      flash_dq_oe_o                 <= 1'b0;
      chip_sel_n_o                  <= 1'b1;
      out_gate_n_o                  <= 1'b1;
      write_strobe_n_o              <= 1'b1;
      program_supply_raised_level_o <= 1'b0;
      addr_bit_nine_hv_o            <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          cmd_ready_o <= 1'b1;
          if (cmd_valid_i && cmd_ready_o) begin
            cmd_ready_o <= 1'b0;
            fail_o      <= 1'b0;
            op_q        <= pfcu_pkg::pfcu_op_t'(cmd_op_i);
            addr_q      <= cmd_addr_i;
            data_q      <= cmd_data_i;
            step_q      <= 4'h0;
            try_q       <= '0;
            // The supply settles before any bus cycle; a rising supply puts the device in array read.
            program_supply_raised_level_o <= (cmd_op_i != 3'(pfcu_pkg::PFCU_OP_IDENT_HV));
            addr_bit_nine_hv_o <= (cmd_op_i == 3'(pfcu_pkg::PFCU_OP_IDENT_HV));
            cnt_q   <= pfcu_pkg::CNT_W'(pfcu_pkg::VPS_CYC);
            state_q <= ST_WAIT;
          end
        end
        ST_SEQ: begin
          step_q <= act_step;
          case (act)
            pfcu_pkg::PFCU_ACT_WR: begin
              flash_addr_o  <= addr_q;
              flash_dq_o    <= act_byte;
              flash_dq_oe_o <= 1'b1;
              out_gate_n_o  <= 1'b1;
              chip_sel_n_o  <= 1'b0;
              cnt_q         <= pfcu_pkg::CNT_W'(pfcu_pkg::CS_CYC);
              state_q       <= ST_WR_SET;
            end
            pfcu_pkg::PFCU_ACT_RD: begin
              flash_addr_o  <= addr_q;
              flash_dq_oe_o <= 1'b0;
              chip_sel_n_o  <= 1'b0;
              out_gate_n_o  <= 1'b0;
              cnt_q         <= pfcu_pkg::CNT_W'(pfcu_pkg::ACC_CYC);
              state_q       <= ST_RD;
            end
            pfcu_pkg::PFCU_ACT_WAIT: begin
              cnt_q   <= act_cnt;
              state_q <= ST_WAIT;
            end
            pfcu_pkg::PFCU_ACT_RETRY: begin
              try_q   <= try_q + 1'b1;
              step_q  <= 4'h0;
              state_q <= ST_SEQ;
            end
            pfcu_pkg::PFCU_ACT_NEXT: begin
              addr_q  <= addr_q + 1'b1;
              step_q  <= 4'h3;
              state_q <= ST_SEQ;
            end
            pfcu_pkg::PFCU_ACT_FAIL: begin
              fail_o             <= 1'b1;
              done_o             <= 1'b1;
              addr_bit_nine_hv_o <= 1'b0;
              state_q            <= ST_IDLE;
            end
            default: begin
              rdata_o            <= rd_q;
              done_o             <= 1'b1;
              addr_bit_nine_hv_o <= 1'b0;
              state_q            <= ST_IDLE;
            end
          endcase
        end
        ST_WR_SET: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == pfcu_pkg::CNT_W'(1)) begin
            write_strobe_n_o <= 1'b0;
            cnt_q            <= pfcu_pkg::CNT_W'(pfcu_pkg::WP_CYC);
            state_q          <= ST_WR_PULSE;
          end
        end
        ST_WR_PULSE: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == pfcu_pkg::CNT_W'(1)) begin
            // Data stays driven past the rising strobe edge, where the device takes it.
            write_strobe_n_o <= 1'b1;
            cnt_q            <= pfcu_pkg::CNT_W'(pfcu_pkg::HOLD_CYC);
            state_q          <= ST_WR_HOLD;
          end
        end
        ST_WR_HOLD: begin
          cnt_q         <= cnt_q - 1'b1;
          chip_sel_n_o  <= 1'b1;
          if (cnt_q == pfcu_pkg::CNT_W'(1)) begin
            flash_dq_oe_o <= 1'b0;
            state_q       <= ST_SEQ;
          end
        end
        ST_RD: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == pfcu_pkg::CNT_W'(1)) begin
            rd_q         <= dq_s2_q;
            chip_sel_n_o <= 1'b1;
            out_gate_n_o <= 1'b1;
            cnt_q        <= pfcu_pkg::CNT_W'(pfcu_pkg::DF_CYC);
            state_q      <= ST_RD_FLOAT;
          end
        end
        ST_RD_FLOAT, ST_WAIT: begin
          // Holding off here keeps our drivers off the bus until the device floats it.
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q <= pfcu_pkg::CNT_W'(1)) begin
            state_q <= ST_SEQ;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // pfcu_host

// File: rtl/pfcu_pkg.sv
// Constants and types shared by the parallel flash command unit host controller.
package pfcu_pkg;
  localparam int CLK_NS = 20;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 17'h1_ffff;
  // Command bytes and the erased byte value.
  localparam logic [7:0] CMD_READ   = 8'h00;
  localparam logic [7:0] CMD_PROG   = 8'h40;
  localparam logic [7:0] CMD_PVER   = 8'hc0;
  localparam logic [7:0] CMD_ERASE  = 8'h20;
  localparam logic [7:0] CMD_EVER   = 8'ha0;
  localparam logic [7:0] CMD_RESET  = 8'hff;
  localparam logic [7:0] CMD_IDENT  = 8'h90;
  localparam logic [7:0] ERASED_VAL = 8'hff;
  // Bus timing in ns; the slowest speed grade is assumed.
  localparam int T_CS_NS  = 20;
  localparam int T_WP_NS  = 60;
  localparam int T_WC_NS  = 200;
  localparam int T_ACC_NS = 200;
  localparam int T_DF_NS  = 30;
  localparam int SYNC_CYC = 2;
  localparam int CS_CYC   = (T_CS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WC_CYC   = (T_WC_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = WC_CYC - WP_CYC - CS_CYC;
  localparam int ACC_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
  localparam int DF_CYC   = (T_DF_NS + CLK_NS - 1) / CLK_NS;
  // Operation times in their own units.
  localparam int T_PROG_US  = 10;
  localparam int T_REC_US   = 6;
  localparam int T_VPS_US   = 1;
  localparam int T_ERASE_US = 9500;
  localparam int PROG_CYC   = (T_PROG_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int REC_CYC    = (T_REC_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int VPS_CYC    = (T_VPS_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_CYC  = (T_ERASE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W      = 20;
  localparam int PROG_TRIES  = 25;
  localparam int ERASE_TRIES = 3000;
  localparam int TRY_W       = 12;
  typedef enum logic [2:0] {
    PFCU_OP_READ,
    PFCU_OP_PROGRAM,
    PFCU_OP_ERASE,
    PFCU_OP_IDENT,
    PFCU_OP_RESET,
    PFCU_OP_IDENT_HV
  } pfcu_op_t;
  typedef enum logic [2:0] {
    PFCU_ACT_WR,
    PFCU_ACT_RD,
    PFCU_ACT_WAIT,
    PFCU_ACT_RETRY,
    PFCU_ACT_NEXT,
    PFCU_ACT_DONE,
    PFCU_ACT_FAIL
  } pfcu_act_t;
endpackage

// File: dv/pfcu_host_assertions.sv
// Concurrent checks on the flash host controller pins and request handshake.
`timescale 1ns/100ps
module pfcu_host_assertions #(
  parameter int ERASE_WAIT = 50
) (
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        cmd_valid_i,
  input wire logic [2:0]  cmd_op_i,
  input wire logic        cmd_ready_o,
  input wire logic        done_o,
  input wire logic        fail_o,
  input wire logic [16:0] flash_addr_o,
  input wire logic [7:0]  flash_dq_o,
  input wire logic        flash_dq_oe_o,
  input wire logic        chip_sel_n_o,
  input wire logic        out_gate_n_o,
  input wire logic        write_strobe_n_o,
  input wire logic        program_supply_raised_level_o,
  input wire logic        addr_bit_nine_hv_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  write_bus_state_a: assert property (
    !write_strobe_n_o |-> !chip_sel_n_o && out_gate_n_o && flash_dq_oe_o)
    else $error("write strobe low outside a write bus state");
  read_no_clash_a: assert property (
    !out_gate_n_o |-> write_strobe_n_o && !chip_sel_n_o && !flash_dq_oe_o)
    else $error("output gate low while host drives data");
  strobe_width_a: assert property (
    $fell(write_strobe_n_o) |-> !write_strobe_n_o [*3] ##[1:2] write_strobe_n_o)
    else $error("write strobe pulse has the wrong width");
  write_hold_a: assert property (
    !write_strobe_n_o |-> $stable(flash_dq_o) && $stable(flash_addr_o))
    else $error("address or data moved during the write strobe");
  write_supply_a: assert property (
    !write_strobe_n_o |-> program_supply_raised_level_o)
    else $error("command write without raised supply");
  hv_supply_a: assert property (
    addr_bit_nine_hv_o |-> !program_supply_raised_level_o)
    else $error("high voltage on address bit nine with raised supply");
  // Known operations open a bus cycle after the supply setup wait.
  take_drops_a: assert property (
    cmd_valid_i && cmd_ready_o && cmd_op_i <= 3'h5 |=>
      !cmd_ready_o ##[1:60] (!write_strobe_n_o || !out_gate_n_o))
    else $error("ready or bus cycle wrong after a request");
  // Unknown operations never touch the bus and end in failure after the setup wait.
  bad_op_fails_a: assert property (
    cmd_valid_i && cmd_ready_o && cmd_op_i > 3'h5 |=>
      !cmd_ready_o ##[1:60] (done_o && fail_o))
    else $error("unknown operation did not end in failure");
  done_pulse_a: assert property (
    done_o |=> !done_o && cmd_ready_o)
    else $error("done not a single pulse followed by ready");
  idle_strobes_a: assert property (
    cmd_ready_o |-> chip_sel_n_o && write_strobe_n_o && out_gate_n_o)
    else $error("strobes active while idle");
  fail_with_done_a: assert property (
    $rose(fail_o) |-> done_o)
    else $error("fail raised without done");
  cover property (done_o && !fail_o && program_supply_raised_level_o);
  cover property (done_o && fail_o);
  cover property (done_o && !program_supply_raised_level_o);
endmodule // pfcu_host_assertions

bind pfcu_host pfcu_host_assertions #(.ERASE_WAIT(ERASE_WAIT)) u_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
  .done_o(done_o), .fail_o(fail_o), .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
  .flash_dq_oe_o(flash_dq_oe_o), .chip_sel_n_o(chip_sel_n_o), .out_gate_n_o(out_gate_n_o),
  .write_strobe_n_o(write_strobe_n_o), .cmd_op_i(cmd_op_i),
  .program_supply_raised_level_o(program_supply_raised_level_o),
  .addr_bit_nine_hv_o(addr_bit_nine_hv_o));

// File: dv/pfcu_flash_model.sv
// Behavioural model of the parallel flash device driven by the host controller.
`timescale 1ns/100ps
module pfcu_flash_model #(
  parameter logic [7:0] MFR_ID = 8'h3c,  // Arbitrary value.
  parameter logic [7:0] DEV_ID = 8'hc3   // Arbitrary value.
) (
  input  wire logic        cs_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        supply_i,
  input  wire logic        hv_i,
  input  wire logic [16:0] addr_i,
  input  wire logic [7:0]  dq_i,
  output logic [7:0]       dq_o
);
  logic [7:0]  mem [0:131071];
  logic [16:0] lat_q, pa_q, ea_q;
  logic [1:0]  mode_q;  // 0 array, 1 ident, 2 program check, 3 erase check.
  logic        prog_set_q, erase_set_q, reset_set_q, bad_pver;
  logic [7:0]  last_q, rd;
  int          n_prog;
  initial begin
    for (int i = 0; i < 131072; i++) mem[i] = 8'hff;
    {mode_q, prog_set_q, erase_set_q, reset_set_q, bad_pver, last_q, n_prog} = '0;
  end
  always @(posedge supply_i) {mode_q, prog_set_q, erase_set_q, reset_set_q} = '0;
  always @(negedge we_n_i) if (!cs_n_i) lat_q = addr_i;
  // Work completes at the strobe rise, well inside the internal timer budget.
  always @(posedge we_n_i) if (!cs_n_i && supply_i) begin
    if (prog_set_q) begin
      mem[lat_q] = dq_i;
      pa_q = lat_q;
      n_prog++;
      prog_set_q = 1'b0;
    end else if (erase_set_q) begin
      if (dq_i == 8'h20) for (int i = 0; i < 131072; i++) mem[i] = 8'hff;
      erase_set_q = 1'b0;
    end else begin
      if (dq_i == 8'h00) mode_q = 2'd0;
      if (dq_i == 8'h90) mode_q = 2'd1;
      if (dq_i == 8'hc0) mode_q = 2'd2;
      if (dq_i == 8'ha0) {mode_q, ea_q} = {2'd3, lat_q};
      if (dq_i == 8'hff && reset_set_q) mode_q = 2'd0;
      prog_set_q = dq_i == 8'h40;
      erase_set_q = dq_i == 8'h20;
      reset_set_q = dq_i == 8'hff && !reset_set_q;
    end
  end
  always_comb begin
    if (hv_i && !supply_i) rd = addr_i[0] ? DEV_ID : MFR_ID;
    else if (mode_q == 2'd1) rd = addr_i[0] ? DEV_ID : MFR_ID;
    else if (mode_q == 2'd2) rd = bad_pver ? ~mem[pa_q] : mem[pa_q];
    else if (mode_q == 2'd3) rd = mem[ea_q];
    else rd = mem[addr_i];
  end
  always @(posedge oe_n_i) last_q = rd;
  // A released bus shows the inverse of the last byte so stale data never matches.
  assign dq_o = (!cs_n_i && !oe_n_i && we_n_i) ? rd : ~last_q;
endmodule // pfcu_flash_model

// File: dv/test_parallel_flash_command_unit.sv
// Self-checking testbench for the flash host controller against a device model.
`timescale 1ns/100ps
module test_parallel_flash_command_unit;
  logic        clock_i = 0, rst_n_i = 0, cmd_valid_i = 0;
  logic [2:0]  cmd_op_i = 0;
  logic [16:0] cmd_addr_i = 0, flash_addr_o;
  logic [7:0]  cmd_data_i = 0, rdata_o, flash_dq_o, dev_dq, bus;
  logic        cmd_ready_o, done_o, fail_o, flash_dq_oe_o, chip_sel_n_o, out_gate_n_o;
  logic        write_strobe_n_o, supply, hv;
  int          n_mismatch = 0, n_checks = 0, np;
  always #10 clock_i = ~clock_i;
  pfcu_host #(.ERASE_WAIT(50)) u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
    .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o), .fail_o(fail_o),
    .rdata_o(rdata_o), .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(bus), .chip_sel_n_o(chip_sel_n_o),
    .out_gate_n_o(out_gate_n_o), .write_strobe_n_o(write_strobe_n_o),
    .program_supply_raised_level_o(supply), .addr_bit_nine_hv_o(hv));
  pfcu_flash_model u_dev (.cs_n_i(chip_sel_n_o), .oe_n_i(out_gate_n_o),
    .we_n_i(write_strobe_n_o), .supply_i(supply), .hv_i(hv), .addr_i(flash_addr_o),
    .dq_i(bus), .dq_o(dev_dq));
  assign bus = flash_dq_oe_o ? flash_dq_o : dev_dq;
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task run_op(input logic [2:0] op, input logic [16:0] a, input logic [7:0] d);
    int n;
    @(posedge clock_i);
    {cmd_valid_i, cmd_op_i, cmd_addr_i, cmd_data_i} <= {1'b1, op, a, d};
    n = 0;
    do begin @(posedge clock_i); n++; end while (cmd_ready_o !== 1'b1 && n < 100);
    cmd_valid_i <= 1'b0;
    // A request that is never taken is a hang as well.
    if (cmd_ready_o !== 1'b1) begin n_mismatch++; test_done(); end
    n = 0;
    do begin @(posedge clock_i); n++; end while (done_o !== 1'b1 && n < 30000);
    if (done_o !== 1'b1) begin n_mismatch++; test_done(); end
  endtask
  task t_program;
    run_op(3'd1, 17'h1_2345, 8'h5a);
    chk({7'h00, fail_o}, 8'h00);
    chk(u_dev.mem[17'h1_2345], 8'h5a);
    run_op(3'd0, 17'h1_2345, 8'h00);
    chk(rdata_o, 8'h5a);
  endtask
  task t_ident;
    for (int i = 0; i < 2; i++) begin
      run_op(3'd3, 17'(i), 8'h00);
      chk(rdata_o, i ? 8'hc3 : 8'h3c);
      run_op(3'd5, 17'(i), 8'h00);
      chk(rdata_o, i ? 8'hc3 : 8'h3c);
      chk({7'h00, supply}, 8'h00);
    end
  endtask
  task t_reset;
    run_op(3'd4, 17'h0_0000, 8'h00);
    chk({7'h00, fail_o}, 8'h00);
    run_op(3'd0, 17'h1_2345, 8'h00);
    chk(rdata_o, 8'h5a);
  endtask
  task t_erase;
    run_op(3'd2, 17'h1_fffe, 8'h00);
    chk({7'h00, fail_o}, 8'h00);
    chk(u_dev.mem[17'h1_2345], 8'hff);
    chk(u_dev.ea_q[7:0], 8'hff);
    chk(rdata_o, 8'hff);
  endtask
  task t_refusals;
    run_op(3'd7, 17'h0_0000, 8'h00);
    chk({7'h00, fail_o}, 8'h01);
    u_dev.bad_pver = 1'b1;
    np = u_dev.n_prog;
    run_op(3'd1, 17'h0_0100, 8'h33);
    chk({7'h00, fail_o}, 8'h01);
    chk(8'(u_dev.n_prog - np), 8'h19);
    u_dev.bad_pver = 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_program();
    t_ident();
    t_reset();
    t_erase();
    t_refusals();
    test_done();
  end
endmodule // test_parallel_flash_command_unit
